// ### include/tsm_pkg.sv
// constants and register map of the timing skew measurement block
// ****************************************************************
// Summary of operation
// ****************************************************************
// Summary of operation
// - reference stream picked by 5-bit select
// - measurement stream picked by 5-bit select
// - offset window is 2^(code+1) samples
// - drift window equals offset up to 16
// - sliding average over newest N samples
// - offset full flag set from Nth sample
// - drift full flag uses drift window
// - partial averages published before window fills
// - offset 62-bit signed, eight bytes at 0x3A2C
// - offset sign folded into plus/minus half UI
// - UI from coarse reference period average
// - drift 62-bit signed, eight bytes at 0x3A34
// - equal frequencies give zero drift
// - skew step reaching UI/16 sets D5
// - reference tags-only drops untagged stamps
// - measurement tags-only drops untagged stamps
package tsm_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] TSM_IDX_WINDOW = 16'h2A14;
    localparam logic [15:0] TSM_IDX_REF_CFG = 16'h2A15;
    localparam logic [15:0] TSM_IDX_MEAS_CFG = 16'h2A16;
    localparam logic [15:0] TSM_IDX_STATUS = 16'h300C;
    localparam logic [15:0] TSM_IDX_MASK = 16'h300D;
    localparam logic [15:0] TSM_IDX_OFFSET = 16'h3A2C;
    localparam logic [15:0] TSM_IDX_DRIFT = 16'h3A34;
    localparam int TSM_RES_BYTES = 8;
    localparam int TSM_ADDR_LSB = 2;
    localparam int TSM_IDX_W = 16;
    // field layout
    localparam int TSM_SEL_W = 5;
    localparam int TSM_TAGS_BIT = 5;
    localparam int TSM_WIN_W = 4;
    localparam int TSM_LIMIT_BIT = 5;
    localparam int TSM_RES_W = 62;
    localparam int TSM_FULL_BIT = 63;
    localparam int TSM_SUM_W = 80;
    localparam int TSM_CNT_W = 17;
    localparam int TSM_DRIFT_LOG = 4;
    localparam int TSM_UI_SHIFT = 3;
    localparam int TSM_LIMIT_SHIFT = 4;
    localparam logic [7:0] TSM_CFG_RST = 8'h00;
    localparam logic [1:0] TSM_HTRANS_NONSEQ = 2'h2;
endpackage

// ### core/tsm_core.sv
// skew measurement processor with its AHB-Lite register slave
`timescale 1ns/1ps
module tsm_core #(
    parameter int NSRC = 32,
    parameter int TSW = 64,
    parameter int MAXN_LOG = 16
) (
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [NSRC-1:0] ts_valid, // one-cycle stamp strobe per source
    input wire logic [NSRC-1:0] ts_tag, // stamp carries a tag
    input wire logic [NSRC*TSW-1:0] ts_time, // stamp times, 2^-16 ps units
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // word only
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp, // always OKAY
    output logic irq // level, unmasked status pending
);
    import tsm_pkg::*;

    localparam int HIST = 1 << MAXN_LOG;
    localparam int RW = tsm_pkg::TSM_RES_W;
    localparam int SW = tsm_pkg::TSM_SUM_W;
    localparam int CW = tsm_pkg::TSM_CNT_W;

    if (NSRC < 1 || NSRC > (1 << TSM_SEL_W) || TSW < RW || MAXN_LOG < TSM_DRIFT_LOG
        || MAXN_LOG > CW - 1) begin : g_bad_param
        $error("tsm_core: unsupported parameter set");
    end

    typedef struct packed {
        logic [7:0] win;
        logic [7:0] ref_cfg;
        logic [7:0] meas_cfg;
        logic [7:0] sts;
        logic [7:0] msk;
        logic dp_wr;
        logic [TSM_IDX_W-1:0] dp_idx;
        logic [31:0] rdata;
        logic [TSW-1:0] ref_last;
        logic ref_seen;
        logic [TSW-1:0] ui;
        logic ui_ok;
        logic [RW-1:0] skew_prev;
        logic skew_ok;
        logic [SW-1:0] off_sum;
        logic [CW-1:0] off_cnt;
        logic [MAXN_LOG-1:0] off_ptr;
        logic [RW-1:0] off_res;
        logic [SW-1:0] dr_sum;
        logic [CW-1:0] dr_cnt;
        logic [TSM_DRIFT_LOG-1:0] dr_ptr;
        logic [RW-1:0] dr_res;
    } tsm_state_s;

    tsm_state_s st_q;
    tsm_state_s st_d;

    // sample history; too large for the state vector
    logic [RW-1:0] off_hist [0:HIST-1];
    logic [RW-1:0] dr_hist [0:(1 << TSM_DRIFT_LOG)-1];

    logic [TSM_SEL_W-1:0] ref_sel;
    logic [TSM_SEL_W-1:0] meas_sel;
    logic ref_take;
    logic meas_take;
    logic [TSW-1:0] ref_t;
    logic [TSW-1:0] meas_t;
    logic [TSW-1:0] base_t;
    logic [TSW-1:0] period;
    logic [TSW-1:0] skew_raw;
    logic [TSW-1:0] skew_fold;
    logic [TSW-1:0] half_ui;
    logic [RW-1:0] skew;
    logic [RW-1:0] step;
    logic [RW-1:0] step_abs;
    logic smp;
    logic dr_smp;
    logic limit_hit;
    logic [CW-1:0] n_off;
    logic [CW-1:0] n_dr;
    logic off_full;
    logic dr_full;
    logic [SW-1:0] off_sum_n;
    logic [SW-1:0] dr_sum_n;
    logic [CW-1:0] off_cnt_n;
    logic [CW-1:0] dr_cnt_n;
    logic [63:0] off_word;
    logic [63:0] dr_word;
    logic a_phase;
    logic [TSM_IDX_W-1:0] a_idx;
    logic cfg_chg;
    logic [7:0] wb;
    logic [31:0] rd_mux;

    // ****************************************************************
    // source selection and tag filter
    // ****************************************************************
    assign ref_sel = st_q.ref_cfg[TSM_SEL_W-1:0];
    assign meas_sel = st_q.meas_cfg[TSM_SEL_W-1:0];

    always_comb begin
        ref_take = 1'b0;
        meas_take = 1'b0;
        ref_t = '0;
        meas_t = '0;
        if (int'(ref_sel) < NSRC) begin
            // untagged stamps vanish here when tags-only is set
            ref_take = ts_valid[ref_sel]
                && (!st_q.ref_cfg[TSM_TAGS_BIT] || ts_tag[ref_sel]);
            ref_t = ts_time[ref_sel*TSW +: TSW];
        end
        if (int'(meas_sel) < NSRC) begin
            meas_take = ts_valid[meas_sel]
                && (!st_q.meas_cfg[TSM_TAGS_BIT] || ts_tag[meas_sel]);
            meas_t = ts_time[meas_sel*TSW +: TSW];
        end
    end

    // ****************************************************************
    // skew sample, folded into one unit interval
    // ****************************************************************
    assign period = ref_t - st_q.ref_last;
    // a reference edge in the same cycle is the newer base
    assign base_t = ref_take ? ref_t : st_q.ref_last;
    assign half_ui = st_q.ui >> 1;
    assign skew_raw = meas_t - base_t;

    always_comb begin
        skew_fold = skew_raw;
        // jitter near the fold point can flip the sign
        if ($signed(skew_raw) > $signed(half_ui)) begin
            skew_fold = skew_raw - st_q.ui;
        end else if ($signed(skew_raw) < -$signed(half_ui)) begin
            skew_fold = skew_raw + st_q.ui;
        end
    end

    assign skew = skew_fold[RW-1:0];
    assign smp = meas_take && st_q.ui_ok && (ref_take || st_q.ref_seen);
    assign dr_smp = smp && st_q.skew_ok;
    // drift sample is the cycle-to-cycle skew change; zero when rates match
    assign step = skew - st_q.skew_prev;
    assign step_abs = $signed(step) < 0 ? -step : step;
    assign limit_hit = dr_smp
        && ({{(TSW-RW){1'b0}}, step_abs} >= (st_q.ui >> TSM_LIMIT_SHIFT));

    // ****************************************************************
    // window lengths and moving sums
    // ****************************************************************
    always_comb begin
        // one bit wider, so that code 15 does not wrap to a shift of zero
        n_off = CW'(1) << ({1'b0, st_q.win[TSM_WIN_W-1:0]} + 5'h01);
        if (int'(st_q.win[TSM_WIN_W-1:0]) + 1 > MAXN_LOG) begin
            n_off = CW'(1) << MAXN_LOG;
        end
        n_dr = n_off;
        if (int'(st_q.win[TSM_WIN_W-1:0]) + 1 > TSM_DRIFT_LOG) begin
            n_dr = CW'(1) << TSM_DRIFT_LOG;
        end
    end

    assign off_full = st_q.off_cnt == n_off;
    assign dr_full = st_q.dr_cnt == n_dr;

    // once full, the oldest entry drops out as the newest enters
    assign off_sum_n = st_q.off_sum + SW'($signed(skew))
        - (off_full ? SW'($signed(off_hist[st_q.off_ptr])) : '0);
    assign dr_sum_n = st_q.dr_sum + SW'($signed(step))
        - (dr_full ? SW'($signed(dr_hist[st_q.dr_ptr])) : '0);
    assign off_cnt_n = off_full ? st_q.off_cnt : st_q.off_cnt + 1'b1;
    assign dr_cnt_n = dr_full ? st_q.dr_cnt : st_q.dr_cnt + 1'b1;

    // bit 63 is the full-window flag, bit 62 repeats the sign
    assign off_word = {off_full, st_q.off_res[RW-1], st_q.off_res};
    assign dr_word = {dr_full, st_q.dr_res[RW-1], st_q.dr_res};

    // ****************************************************************
    // bus decode
    // ****************************************************************
    assign a_phase = hsel && hready && htrans == TSM_HTRANS_NONSEQ;
    assign a_idx = haddr[TSM_ADDR_LSB +: TSM_IDX_W];
    assign wb = hwdata[7:0];
    assign cfg_chg = st_q.dp_wr && (
        (st_q.dp_idx == TSM_IDX_WINDOW && wb != st_q.win)
        || (st_q.dp_idx == TSM_IDX_REF_CFG && wb != st_q.ref_cfg)
        || (st_q.dp_idx == TSM_IDX_MEAS_CFG && wb != st_q.meas_cfg));

    always_comb begin
        rd_mux = '0;
        unique case (a_idx)
            TSM_IDX_WINDOW: rd_mux[7:0] = st_q.win;
            TSM_IDX_REF_CFG: rd_mux[7:0] = st_q.ref_cfg;
            TSM_IDX_MEAS_CFG: rd_mux[7:0] = st_q.meas_cfg;
            TSM_IDX_STATUS: rd_mux[7:0] = st_q.sts;
            TSM_IDX_MASK: rd_mux[7:0] = st_q.msk;
            default: begin
                for (int k = 0; k < TSM_RES_BYTES; k++) begin
                    if (a_idx == TSM_IDX_OFFSET + TSM_IDX_W'(k)) begin
                        rd_mux[7:0] = off_word[8*k +: 8];
                    end
                    if (a_idx == TSM_IDX_DRIFT + TSM_IDX_W'(k)) begin
                        rd_mux[7:0] = dr_word[8*k +: 8];
                    end
                end
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.dp_wr = a_phase && hwrite;
        st_d.dp_idx = a_idx;
        if (a_phase && !hwrite) begin
            st_d.rdata = rd_mux;
        end
        // reference period tracking
        if (ref_take) begin
            st_d.ref_last = ref_t;
            st_d.ref_seen = 1'b1;
            if (st_q.ref_seen && !st_q.ui_ok) begin
                st_d.ui = period;
                st_d.ui_ok = 1'b1;
            end else if (st_q.ref_seen) begin
                // coarse first-order average, cheap and slow to move
                st_d.ui = st_q.ui
                    + TSW'($signed(period - st_q.ui) >>> TSM_UI_SHIFT);
            end
        end
        if (smp) begin
            st_d.skew_prev = skew;
            st_d.skew_ok = 1'b1;
            st_d.off_sum = off_sum_n;
            st_d.off_cnt = off_cnt_n;
            st_d.off_ptr = (CW'(st_q.off_ptr) == n_off - 1'b1) ? '0 : st_q.off_ptr + 1'b1;
            // divide by the samples held so far, full or not
            st_d.off_res = RW'($signed(off_sum_n) / $signed(SW'(off_cnt_n)));
        end
        if (dr_smp) begin
            st_d.dr_sum = dr_sum_n;
            st_d.dr_cnt = dr_cnt_n;
            st_d.dr_ptr = (CW'(st_q.dr_ptr) == n_dr - 1'b1) ? '0 : st_q.dr_ptr + 1'b1;
            st_d.dr_res = RW'($signed(dr_sum_n) / $signed(SW'(dr_cnt_n)));
        end
        // status: write one to clear, a new event wins
        if (st_q.dp_wr && st_q.dp_idx == TSM_IDX_STATUS) begin
            st_d.sts = st_q.sts & ~wb;
        end
        if (limit_hit) begin
            st_d.sts[TSM_LIMIT_BIT] = 1'b1;
        end
        if (st_q.dp_wr) begin
            unique case (st_q.dp_idx)
                TSM_IDX_WINDOW: st_d.win = wb;
                TSM_IDX_REF_CFG: st_d.ref_cfg = wb;
                TSM_IDX_MEAS_CFG: st_d.meas_cfg = wb;
                TSM_IDX_MASK: st_d.msk = wb;
                default: st_d.msk = st_d.msk;
            endcase
        end
        // new sources or window: start a fresh sequence
        if (cfg_chg) begin
            st_d.ref_seen = 1'b0;
            st_d.ui_ok = 1'b0;
            st_d.skew_ok = 1'b0;
            st_d.off_sum = '0;
            st_d.off_cnt = '0;
            st_d.off_ptr = '0;
            st_d.dr_sum = '0;
            st_d.dr_cnt = '0;
            st_d.dr_ptr = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // history written only while the sample is live; stale entries never summed
    always_ff @(posedge clk_sys) begin
        if (smp) begin
            off_hist[st_q.off_ptr] <= skew;
        end
        if (dr_smp) begin
            dr_hist[st_q.dr_ptr] <= step;
        end
    end

    assign hrdata = st_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign irq = |(st_q.sts & st_q.msk);

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_cfg_write;
        st_q.dp_wr && cfg_chg;
    endsequence

    sequence s_restarted;
        st_q.off_cnt == '0 && st_q.dr_cnt == '0 && !st_q.skew_ok;
    endsequence

    a_ref_capture: assert property (@(posedge clk_sys) disable iff (!nrst)
        ref_take && !cfg_chg |=> st_q.ref_last == $past(ref_t) && st_q.ref_seen)
        else $error("reference stamp not captured");

    a_meas_sample: assert property (@(posedge clk_sys) disable iff (!nrst)
        smp && !off_full && !cfg_chg |=> st_q.off_cnt == $past(st_q.off_cnt) + 1'b1)
        else $error("measurement sample not counted");

    a_off_window: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q.off_cnt <= n_off && n_off >= CW'(2) && n_off <= (CW'(1) << MAXN_LOG))
        else $error("offset window length out of range");

    a_drift_window: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q.win[TSM_WIN_W-1:0] >= 4'h3 |-> n_dr == CW'(16))
        else $error("drift window not fixed at sixteen");

    a_off_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(off_word[TSM_FULL_BIT]) |-> $past(smp) && st_q.off_cnt == n_off)
        else $error("offset full flag rose without the Nth sample");

    a_drift_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
        dr_word[TSM_FULL_BIT] |-> st_q.dr_cnt == n_dr && st_q.dr_cnt <= CW'(16))
        else $error("drift full flag without full drift window");

    a_tag_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
        ts_valid[ref_sel] && !ts_tag[ref_sel] && st_q.ref_cfg[TSM_TAGS_BIT] && !cfg_chg
        |=> $stable(st_q.ref_last))
        else $error("untagged reference stamp was used");

    a_limit_flag: assert property (@(posedge clk_sys) disable iff (!nrst)
        limit_hit |=> st_q.sts[TSM_LIMIT_BIT] ##1 irq || !st_q.msk[TSM_LIMIT_BIT]
            || !st_q.sts[TSM_LIMIT_BIT])
        else $error("limit exceeded status not raised");

    a_cfg_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
        s_cfg_write |=> s_restarted ##0 !off_full)
        else $error("configuration change did not restart averaging");

    a_meas_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
        ts_valid[meas_sel] && !ts_tag[meas_sel] && st_q.meas_cfg[TSM_TAGS_BIT] && !cfg_chg
        |=> $stable(st_q.off_cnt) && $stable(st_q.skew_prev))
        else $error("untagged measurement stamp was used");

    a_first_partial: assert property (@(posedge clk_sys) disable iff (!nrst)
        smp && !cfg_chg && st_q.off_cnt == '0 |=> st_q.off_res == $past(skew))
        else $error("first partial offset not published");

    a_ui_start: assert property (@(posedge clk_sys) disable iff (!nrst)
        ref_take && st_q.ref_seen && !st_q.ui_ok && !cfg_chg
        |=> st_q.ui_ok && st_q.ui == $past(period))
        else $error("unit interval not taken from the first period");

    a_status_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
        st_q.dp_wr && st_q.dp_idx == TSM_IDX_STATUS && wb[TSM_LIMIT_BIT] && !limit_hit
        |=> !st_q.sts[TSM_LIMIT_BIT])
        else $error("limit status not cleared by a written one");

    a_drift_short: assert property (@(posedge clk_sys) disable iff (!nrst)
        int'(st_q.win[TSM_WIN_W-1:0]) < TSM_DRIFT_LOG |-> n_dr == n_off)
        else $error("drift window differs from offset window");

    a_drift_first: assert property (@(posedge clk_sys) disable iff (!nrst)
        smp && !cfg_chg && !st_q.skew_ok |=> st_q.dr_cnt == $past(st_q.dr_cnt))
        else $error("drift sample taken without a previous skew");

endmodule

// ### sim/tsm_stamp_src.sv
// time stamp source model standing in for the converter outputs
`timescale 1ns/1ps
module tsm_stamp_src #(
    parameter int NSRC = 32,
    parameter int TSW = 64
) (
    input wire logic clk_sys, // system clock
    output logic [NSRC-1:0] ts_valid, // stamp strobes
    output logic [NSRC-1:0] ts_tag, // tag qualifiers
    output logic [NSRC*TSW-1:0] ts_time // stamp times
);
    initial begin
        ts_valid = '0;
        ts_tag = '0;
        ts_time = '0;
    end
    // one stamp; idle lines then flip so a stale time never passes for a fresh one
    task automatic fire(input int k, input logic tag, input logic [TSW-1:0] t, input int gap);
        ts_valid[k] <= 1'b1;
        ts_tag[k] <= tag;
        ts_time[k*TSW +: TSW] <= t;
        @(posedge clk_sys);
        ts_valid[k] <= 1'b0;
        ts_tag <= ~ts_tag;
        ts_time <= ~ts_time;
        repeat (gap) @(posedge clk_sys);
    endtask
endmodule

// ### sim/tsm_core_tb_top.sv
// self-checking bench of the skew measurement block
`timescale 1ns/1ps
module tsm_core_tb_top;
    import tsm_pkg::*;
    localparam logic [63:0] P = 64'h10000;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] ts_valid;
    logic [31:0] ts_tag;
    logic [2047:0] ts_time;
    int n_mismatch = 0;
    int tests_run = 0;
    int rs = 3;
    int ms = 7;
    logic [63:0] tr = 64'h0;
    logic [31:0] rd;
    logic [63:0] r64;
    always #12.5 clk_sys = ~clk_sys;
    tsm_stamp_src #(.NSRC(32), .TSW(64)) src (.clk_sys(clk_sys), .ts_valid(ts_valid),
        .ts_tag(ts_tag), .ts_time(ts_time));
    tsm_core #(.NSRC(32), .TSW(64), .MAXN_LOG(6)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .ts_valid(ts_valid), .ts_tag(ts_tag), .ts_time(ts_time), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    // ****************************************************************
    // bus and check tasks
    // ****************************************************************
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // leading edge gives the idle gap that keeps a read off a pending write
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= {14'h0, idx, 2'h0};
        htrans <= TSM_HTRANS_NONSEQ;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rd64(input logic [15:0] idx);
        for (int k = 0; k < 8; k++) begin
            bus(1'b0, idx + 16'(k), 8'h00);
            r64[8*k +: 8] = rd[7:0];
        end
    endtask
    function automatic logic [63:0] res(input logic f, input longint v);
        return {f, v[62:0]};
    endfunction
    task automatic prime();
        tr = tr + P;
        src.fire(rs, 1'b1, tr, 1);
        tr = tr + P;
        src.fire(rs, 1'b1, tr, 2);
    endtask
    // measurement stamp at a skew after the latest reference, then the next reference
    task automatic meas(input logic [63:0] skew, input logic tag);
        src.fire(ms, tag, tr + skew, 1);
        tr = tr + P;
        src.fire(rs, 1'b1, tr, 1);
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [15:0] idx[5];
        int no;
        int nd;
        idx = '{TSM_IDX_WINDOW, TSM_IDX_REF_CFG, TSM_IDX_MEAS_CFG, TSM_IDX_STATUS, TSM_IDX_MASK};
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        foreach (idx[i]) begin
            bus(1'b0, idx[i], 8'h00);
            check("reset value", rd, 32'h0);
        end
        bus(1'b1, 16'h0123, 8'h5A);
        bus(1'b0, 16'h0123, 8'h00);
        check("unmapped", rd, 32'h0);
        bus(1'b1, TSM_IDX_WINDOW, 8'h01);
        bus(1'b1, TSM_IDX_REF_CFG, 8'h03);
        bus(1'b1, TSM_IDX_MEAS_CFG, 8'h07);
        bus(1'b0, TSM_IDX_MEAS_CFG, 8'h00);
        check("meas cfg", rd, 32'h7);
        check("hresp", hresp, 1'b0);
        // steady drift of 0x200 per sample over a window of four
        prime();
        for (int m = 1; m <= 5; m++) begin
            meas(64'h100 + 64'(m - 1) * 64'h200, 1'b1);
            rd64(TSM_IDX_OFFSET);
            check("offset", r64, res(m >= 4, (m < 5) ? 64'(m) * 64'h100 : 64'h600));
            if (m > 1) begin
                rd64(TSM_IDX_DRIFT);
                check("drift", r64, res(m >= 5, 64'h200));
            end
        end
        // full flags per window code; each new code restarts the sequence
        for (int c = 0; c < 6; c++) begin
            bus(1'b1, TSM_IDX_WINDOW, 8'(c));
            prime();
            no = 2 << c;
            nd = (c > 3) ? 16 : no;
            for (int m = 1; m <= ((no > nd) ? no : nd + 1); m++) begin
                meas(64'h100, 1'b1);
                bus(1'b0, TSM_IDX_OFFSET + 16'h7, 8'h00);
                check("offset full", rd, {24'h0, m >= no, 7'h0});
                bus(1'b0, TSM_IDX_DRIFT + 16'h7, 8'h00);
                check("drift full", rd, {24'h0, m - 1 >= nd, 7'h0});
            end
        end
        // stamps on sources no longer selected are dropped
        bus(1'b1, TSM_IDX_REF_CFG, 8'h04);
        bus(1'b1, TSM_IDX_MEAS_CFG, 8'h09);
        rs = 4;
        ms = 9;
        prime();
        src.fire(3, 1'b1, tr + 64'h80, 1);
        src.fire(7, 1'b1, tr + 64'h300, 1);
        meas(64'h100, 1'b1);
        rd64(TSM_IDX_OFFSET);
        check("new sources", r64, res(1'b0, 64'h100));
        // untagged reference ignored, so skew folds against the older one
        bus(1'b1, TSM_IDX_REF_CFG, 8'h24);
        prime();
        src.fire(rs, 1'b0, tr + 64'h8000, 1);
        src.fire(ms, 1'b1, tr + 64'h8100, 1);
        rd64(TSM_IDX_OFFSET);
        check("lead sign", r64, res(1'b0, -64'sh7F00));
        bus(1'b1, TSM_IDX_MEAS_CFG, 8'h29);
        prime();
        meas(64'h100, 1'b1);
        meas(64'h500, 1'b0);
        meas(64'h100, 1'b1);
        rd64(TSM_IDX_OFFSET);
        check("meas tags", r64, res(1'b0, 64'h100));
        rd64(TSM_IDX_DRIFT);
        check("equal rate", r64, res(1'b0, 64'h0));
        // a skew step of exactly UI/16 raises the limit event
        bus(1'b1, TSM_IDX_MASK, 8'h20);
        bus(1'b0, TSM_IDX_STATUS, 8'h00);
        check("no limit", {rd, irq}, 33'h0);
        meas(64'h1100, 1'b1);
        bus(1'b0, TSM_IDX_STATUS, 8'h00);
        check("limit", {rd, irq}, 33'h41);
        bus(1'b1, TSM_IDX_MASK, 8'h00);
        // the mask write lands on the edge the task returns at
        @(posedge clk_sys);
        check("masked", irq, 1'b0);
        bus(1'b1, TSM_IDX_STATUS, 8'h20);
        bus(1'b0, TSM_IDX_STATUS, 8'h00);
        check("cleared", rd, 32'h0);
        close_out();
    end
    initial begin
        #(25 * 30000);
        n_mismatch++;
        close_out();
    end
endmodule
